// File: spct_pkg.sv
// Shared constants, register map and types of the sequencer logic core.
// Assumes a 125 MHz hclk; the 250 kHz oscillator divisor is derived from it here.
package spct_pkg;

  localparam int HCLK_FREQ_HZ = 125_000_000;
  localparam int OSC_FREQ_HZ  = 250_000;
  localparam int OSC_DIV      = HCLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int OSC_HALF     = OSC_DIV / 2;
  localparam logic [8:0] OSC_LAST  = 9'(OSC_DIV - 1);
  localparam logic [8:0] OSC_HIGH  = 9'(OSC_HALF);

  localparam int N_MC      = 16;
  localparam int N_IN      = 36;
  localparam int N_PT      = 81;
  localparam int PT_PER_MC = 5;
  localparam int RST_PT    = 80;
  localparam int N_TMR     = 4;
  localparam int N_CMP     = 12;
  localparam int N_DIG     = 4;
  localparam int N_HV      = 4;
  localparam int TMR_W     = 9;
  localparam logic [6:0] PT_COUNT = 7'(N_PT);

  localparam logic [7:0] ADDR_CLK_CFG  = 8'h00;
  localparam logic [7:0] ADDR_OUT_CFG  = 8'h04;
  localparam logic [7:0] ADDR_TMR_GATE = 8'h08;
  localparam logic [7:0] ADDR_TMR_CFG  = 8'h0C;
  localparam logic [7:0] ADDR_PT_SEL   = 8'h10;
  localparam logic [7:0] ADDR_PT_TRUE  = 8'h14;
  localparam logic [7:0] ADDR_PT_COMP  = 8'h18;
  localparam logic [7:0] ADDR_PT_HI    = 8'h1C;
  localparam logic [7:0] ADDR_MC_CFG0  = 8'h20;
  localparam logic [7:0] ADDR_STATUS   = 8'h30;
  localparam logic [7:0] ADDR_MC_MASK  = 8'hF0;

  localparam int CLK_PDIV_LSB = 0;
  localparam int CLK_TDIV_LSB = 4;
  localparam int CLK_EXT_BIT  = 8;
  localparam int PTH_COMP_LSB = 4;
  localparam int PTH_EN_BIT   = 8;
  localparam int MC_T_BIT     = 0;
  localparam int MC_BYP_BIT   = 1;
  localparam int MC_POL_BIT   = 2;
  localparam int MC_LEND_BIT  = 3;
  localparam int MC_RST_LSB   = 4;
  localparam int MC_PRE_LSB   = 6;

  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_PT   = 2'h1;
  localparam logic [1:0] SRC_GRST = 2'h2;
  localparam logic [1:0] SRC_POR  = 2'h3;

  localparam logic [8:0]  CLK_CFG_RST  = 9'h000;
  localparam logic [3:0]  OUT_CFG_RST  = 4'h0;
  localparam logic [15:0] TMR_GATE_RST = 16'h0000;
  localparam logic [11:0] TMR_CFG_RST  = 12'h000;
  localparam logic [7:0]  MC_CFG_RST   = 8'h00;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD_WAIT, BUS_RD_DONE} spct_bus_e;

endpackage

// File: spct_tmr_if.sv
// Link between the array core and the timer bank.
// Assumes both ends run on the same hclk.
`timescale 1ns/1ps
interface spct_tmr_if;
  logic                              tick;
  logic                              clr;
  logic [spct_pkg::N_TMR-1:0]        gate;
  logic [spct_pkg::N_TMR-1:0][2:0]   tsel;
  logic [spct_pkg::N_TMR-1:0]        done;
  modport core (output tick, output clr, output gate, output tsel, input done);
  modport tmr  (input tick, input clr, input gate, input tsel, output done);
endinterface

// File: spct_timers.sv
// Bank of four gated timers sharing one timer tick.
// Assumes tick is a one-cycle pulse on hclk and clr is already synchronised.
`timescale 1ns/1ps
module spct_timers (
  input wire logic hclk,    // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  spct_tmr_if.tmr  tif      // Tick, gates and timeout selects in, done out
);
  import spct_pkg::*;

  typedef struct packed {
    logic [N_TMR-1:0][TMR_W-1:0] cnt;
    logic [N_TMR-1:0]            done;
  } spct_tmr_s;

  spct_tmr_s s_q;
  spct_tmr_s nx;

  // Timeout select k gives 2 << k ticks
  function automatic logic [TMR_W-1:0] term(input logic [2:0] k);
    return (TMR_W)'(2) << k;
  endfunction

  always_comb begin
    nx = s_q;
    for (int t = 0; t < N_TMR; t++) begin
      if (tif.clr || !tif.gate[t]) begin
        nx.cnt[t]  = '0;
        nx.done[t] = 1'b0;
      end else if (tif.tick && !s_q.done[t]) begin
        nx.cnt[t] = s_q.cnt[t] + 9'h001;
        if (nx.cnt[t] == term(tif.tsel[t])) begin
          nx.done[t] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= nx;
    end
  end

  assign tif.done = s_q.done;

  gate_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!tif.gate[0] || tif.clr) |=> (s_q.cnt[0] == '0 && !tif.done[0]))
    else $error("timer not cleared by low gate or reset");

  done_term_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tif.done[0]) |-> ($past(tif.tick) &&
      $past(s_q.cnt[0]) == term($past(tif.tsel[0])) - 9'h001))
    else $error("timer done not at terminal count");

  done_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tif.done[0] && tif.gate[0] && !tif.clr) |=> tif.done[0])
    else $error("timer done dropped while gate high");

  shared_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!tif.tick && tif.gate[1] && !tif.clr) |=> $stable(s_q.cnt[1]))
    else $error("timer counted without a timer tick");

endmodule

// File: spct_core.sv
// Sequencer logic core: clock prescalers, 16-cell logic array, output modes
// and AHB-Lite configuration slave. Instantiates the timer bank.
// Assumes a single AHB-Lite master and asynchronous external pins.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module spct_core (
  input  wire logic                        hclk,       // System clock, 125 MHz
  input  wire logic                        hresetn,    // Power-on reset, active low
  input  wire logic                        hsel,       // AHB slave select
  input  wire logic [31:0]                 haddr,      // AHB address
  input  wire logic [1:0]                  htrans,     // AHB transfer type
  input  wire logic                        hwrite,     // AHB write
  input  wire logic [2:0]                  hsize,      // AHB size, word only
  input  wire logic [31:0]                 hwdata,     // AHB write data
  input  wire logic                        hready,     // AHB bus ready
  output logic      [31:0]                 hrdata,     // AHB read data
  output logic                             hreadyout,  // AHB slave ready
  output logic                             hresp,      // AHB response, always OKAY
  input  wire logic [spct_pkg::N_CMP-1:0]  cmp_in,     // Comparator results
  input  wire logic [spct_pkg::N_DIG-1:0]  dig_in,     // Digital input pins
  input  wire logic                        rst_pin_n,  // Global reset pin, active low
  input  wire logic                        clk_pin_i,  // Clock pin level
  output logic                             clk_pin_o,  // Clock pin drive value
  output logic                             clk_pin_oe, // Clock pin pulls low
  output logic [spct_pkg::N_HV-1:0]        high_voltage_gate_output_drive, // Source on
  output logic [spct_pkg::N_HV-1:0]        high_voltage_gate_output_oe,    // Sink low
  output logic [spct_pkg::N_HV-1:0]        high_voltage_gate_output_o,     // Drive value
  output logic [spct_pkg::N_MC-1:0]        pld_out     // Cell outputs
);
  import spct_pkg::*;

  typedef struct packed {
    spct_bus_e                     bus;
    logic [5:0]                    widx;
    logic                          hit;
    logic [31:0]                   rdata;
    logic [8:0]                    clk_cfg;
    logic [N_HV-1:0]               out_cfg;
    logic [15:0]                   tmr_gate;
    logic [11:0]                   tmr_cfg;
    logic [6:0]                    pt_idx;
    logic [N_PT-1:0][N_IN-1:0]     pt_t;
    logic [N_PT-1:0][N_IN-1:0]     pt_c;
    logic [N_PT-1:0]               pt_en;
    logic [N_MC-1:0][7:0]          mc_cfg;
    logic [15:0]                   cin_s1;
    logic [15:0]                   cin_s2;
    logic                          clk_s1;
    logic                          clk_s2;
    logic                          clk_s3;
    logic                          rst_s1;
    logic                          rst_s2;
    logic [8:0]                    osc_cnt;
    logic [8:0]                    src_cnt;
    logic [19:0]                   samp;
    logic [N_MC-1:0]               mc_q;
    logic [N_MC-1:0]               mc_out;
    logic                          por;
    logic                          clk_oe;
    logic [N_HV-1:0]               hv_drv;
    logic [N_HV-1:0]               hv_oe;
  } spct_core_s;

  // Clock pin stages start at the pulled-up idle level, so no false edge
  localparam spct_core_s CORE_RST = '{bus: BUS_IDLE, por: 1'b1, rst_s1: 1'b1,
                                      rst_s2: 1'b1, clk_s1: 1'b1, clk_s2: 1'b1,
                                      clk_s3: 1'b1, clk_cfg: CLK_CFG_RST,
                                      out_cfg: OUT_CFG_RST, tmr_gate: TMR_GATE_RST,
                                      tmr_cfg: TMR_CFG_RST, default: '0};

  spct_core_s        s_q;
  spct_core_s        nx;
  spct_tmr_if        tif ();
  logic [N_IN-1:0]   in_vec;
  logic [N_PT-1:0]   pt;
  logic [N_MC-1:0]   cluster;
  logic [N_MC-1:0]   lendv;
  logic [N_MC-1:0]   polv;
  logic [N_MC-1:0]   sum;
  logic [N_MC-1:0]   arst;
  logic [N_MC-1:0]   apre;
  logic [N_TMR-1:0]  gatev;
  logic              ext_sel;
  logic              src_rise;
  logic              pld_tick;
  logic              tmr_tick;
  logic              grst;
  logic              pin_level;
  logic              accept;
  logic              pt_ok;
  logic [2:0]        pdiv;
  logic [2:0]        tdiv;
  logic [7:0]        baddr;

  // True when the low n bits of cnt are all ones
  function automatic logic low_ones(input logic [8:0] cnt, input logic [3:0] n);
    logic [8:0] mask;
    mask = ~(9'h1FF << n);
    return (cnt & mask) == mask;
  endfunction

  function automatic logic src_hit(input logic [1:0] sel, input logic ptv,
                                   input logic g, input logic p);
    case (sel)
      SRC_PT:   return ptv;
      SRC_GRST: return g;
      SRC_POR:  return p;
      default:  return 1'b0;
    endcase
  endfunction

  always_comb begin
    nx        = s_q;
    ext_sel   = s_q.clk_cfg[CLK_EXT_BIT];
    pdiv      = s_q.clk_cfg[CLK_PDIV_LSB +: 3];
    tdiv      = s_q.clk_cfg[CLK_TDIV_LSB +: 3];
    grst      = ~s_q.rst_s2;
    accept    = hsel & hready & htrans[1];
    baddr     = {s_q.widx, 2'h0};
    pt_ok     = s_q.pt_idx < PT_COUNT;

    // Pin synchronisers
    nx.cin_s1 = {dig_in, cmp_in};
    nx.cin_s2 = s_q.cin_s1;
    nx.clk_s1 = clk_pin_i;
    nx.clk_s2 = s_q.clk_s1;
    nx.clk_s3 = s_q.clk_s2;
    nx.rst_s1 = rst_pin_n;
    nx.rst_s2 = s_q.rst_s1;

    // 250 kHz oscillator and shared source edge counter
    nx.osc_cnt = (s_q.osc_cnt == OSC_LAST) ? 9'h000 : s_q.osc_cnt + 9'h001;
    src_rise   = ext_sel ? (s_q.clk_s2 & ~s_q.clk_s3) : (s_q.osc_cnt == OSC_LAST);
    nx.src_cnt = s_q.src_cnt + {8'h00, src_rise};
    pld_tick   = src_rise & low_ones(s_q.src_cnt, {1'b0, pdiv});
    tmr_tick   = src_rise & low_ones(s_q.src_cnt, {1'b0, tdiv} + 4'h2);
    pin_level  = (pdiv == 3'h0) ? (nx.osc_cnt < OSC_HIGH) : ~nx.src_cnt[pdiv - 3'h1];
    nx.clk_oe  = ~ext_sel & ~pin_level;
    nx.por     = s_q.por & ~pld_tick;

    if (pld_tick) begin
      nx.samp = {tif.done, s_q.cin_s2};
    end

    // AND array, allocation and sum terms
    in_vec = {s_q.samp[19:16], s_q.mc_out, s_q.samp[15:0]};
    for (int p = 0; p < N_PT; p++) begin
      pt[p] = s_q.pt_en[p] & ~|(s_q.pt_t[p] & ~in_vec) & ~|(s_q.pt_c[p] & in_vec);
    end
    for (int i = 0; i < N_MC; i++) begin
      cluster[i] = |pt[i*PT_PER_MC +: PT_PER_MC];
      lendv[i]   = s_q.mc_cfg[i][MC_LEND_BIT];
      polv[i]    = s_q.mc_cfg[i][MC_POL_BIT];
    end
    // A lending cell passes its cluster to the next cell up
    sum = ((cluster & ~lendv) | {cluster[N_MC-2:0] & lendv[N_MC-2:0], 1'b0}) ^ polv;

    for (int i = 0; i < N_MC; i++) begin
      arst[i] = src_hit(s_q.mc_cfg[i][MC_RST_LSB +: 2], pt[RST_PT], grst, s_q.por);
      apre[i] = src_hit(s_q.mc_cfg[i][MC_PRE_LSB +: 2], pt[i*PT_PER_MC + 4], grst,
                        s_q.por);
      if (arst[i]) begin
        nx.mc_q[i] = 1'b0;
      end else if (apre[i]) begin
        nx.mc_q[i] = 1'b1;
      end else if (pld_tick) begin
        nx.mc_q[i] = s_q.mc_cfg[i][MC_T_BIT] ? (s_q.mc_q[i] ^ sum[i]) : sum[i];
      end
      nx.mc_out[i] = s_q.mc_cfg[i][MC_BYP_BIT] ? sum[i] : nx.mc_q[i];
    end

    // Timer gates and output stages
    for (int t = 0; t < N_TMR; t++) begin
      gatev[t] = s_q.mc_out[s_q.tmr_gate[t*4 +: 4]];
    end
    for (int j = 0; j < N_HV; j++) begin
      nx.hv_drv[j] = s_q.out_cfg[j] & s_q.mc_out[j];
      nx.hv_oe[j]  = ~s_q.mc_out[j];
    end

    // Register slave: writes land in the data phase, reads take one wait state
    if (s_q.bus == BUS_WR && s_q.hit) begin
      case (baddr)
        ADDR_CLK_CFG:  nx.clk_cfg  = hwdata[8:0];
        ADDR_OUT_CFG:  nx.out_cfg  = hwdata[N_HV-1:0];
        ADDR_TMR_GATE: nx.tmr_gate = hwdata[15:0];
        ADDR_TMR_CFG:  nx.tmr_cfg  = hwdata[11:0];
        ADDR_PT_SEL:   nx.pt_idx   = hwdata[6:0];
        ADDR_PT_TRUE: begin
          if (pt_ok) nx.pt_t[s_q.pt_idx][31:0] = hwdata;
        end
        ADDR_PT_COMP: begin
          if (pt_ok) nx.pt_c[s_q.pt_idx][31:0] = hwdata;
        end
        ADDR_PT_HI: begin
          if (pt_ok) begin
            nx.pt_t[s_q.pt_idx][35:32] = hwdata[3:0];
            nx.pt_c[s_q.pt_idx][35:32] = hwdata[PTH_COMP_LSB +: 4];
            nx.pt_en[s_q.pt_idx]       = hwdata[PTH_EN_BIT];
          end
        end
        default: begin
          if ((baddr & ADDR_MC_MASK) == ADDR_MC_CFG0) begin
            for (int j = 0; j < 4; j++) begin
              nx.mc_cfg[{s_q.widx[1:0], 2'(j)}] = hwdata[j*8 +: 8];
            end
          end
        end
      endcase
    end

    if (s_q.bus == BUS_RD_WAIT) begin
      nx.rdata = 32'h0000_0000;
      if (s_q.hit) begin
        case (baddr)
          ADDR_CLK_CFG:  nx.rdata = {23'h00_0000, s_q.clk_cfg};
          ADDR_OUT_CFG:  nx.rdata = {28'h000_0000, s_q.out_cfg};
          ADDR_TMR_GATE: nx.rdata = {16'h0000, s_q.tmr_gate};
          ADDR_TMR_CFG:  nx.rdata = {20'h0_0000, s_q.tmr_cfg};
          ADDR_PT_SEL:   nx.rdata = {25'h000_0000, s_q.pt_idx};
          ADDR_PT_TRUE:  nx.rdata = pt_ok ? s_q.pt_t[s_q.pt_idx][31:0] : 32'h0000_0000;
          ADDR_PT_COMP:  nx.rdata = pt_ok ? s_q.pt_c[s_q.pt_idx][31:0] : 32'h0000_0000;
          ADDR_PT_HI: begin
            if (pt_ok) begin
              nx.rdata = {23'h00_0000, s_q.pt_en[s_q.pt_idx],
                          s_q.pt_c[s_q.pt_idx][35:32], s_q.pt_t[s_q.pt_idx][35:32]};
            end
          end
          ADDR_STATUS:   nx.rdata = {11'h000, s_q.por, tif.done, s_q.mc_out};
          default: begin
            if ((baddr & ADDR_MC_MASK) == ADDR_MC_CFG0) begin
              for (int j = 0; j < 4; j++) begin
                nx.rdata[j*8 +: 8] = s_q.mc_cfg[{s_q.widx[1:0], 2'(j)}];
              end
            end
          end
        endcase
      end
    end

    case (s_q.bus)
      BUS_RD_WAIT: nx.bus = BUS_RD_DONE;
      default: begin
        if (accept) begin
          nx.bus  = hwrite ? BUS_WR : BUS_RD_WAIT;
          nx.widx = haddr[7:2];
          nx.hit  = (haddr[31:8] == 24'h00_0000);
        end else begin
          nx.bus = BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= nx;
    end
  end

  assign tif.tick  = tmr_tick;
  assign tif.clr   = grst;
  assign tif.gate  = gatev;
  assign tif.tsel  = s_q.tmr_cfg;

  spct_timers u_timers (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  assign hrdata     = s_q.rdata;
  assign hreadyout  = (s_q.bus != BUS_RD_WAIT);
  assign hresp      = 1'b0;
  assign clk_pin_o  = 1'b0;
  assign clk_pin_oe = s_q.clk_oe;
  assign pld_out    = s_q.mc_out;
  assign high_voltage_gate_output_drive = s_q.hv_drv;
  assign high_voltage_gate_output_oe    = s_q.hv_oe;
  assign high_voltage_gate_output_o     = '0;

  // Tick spacing monitors for the period checks
  logic [19:0] gap_p;
  logic [19:0] gap_t;
  logic        seen_p;
  logic        seen_t;
  logic [8:0]  cfg_p;
  logic [8:0]  cfg_t;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_p  <= '0;
      gap_t  <= '0;
      seen_p <= 1'b0;
      seen_t <= 1'b0;
      cfg_p  <= '0;
      cfg_t  <= '0;
    end else begin
      gap_p  <= pld_tick ? 20'h0_0000 : gap_p + 20'h0_0001;
      gap_t  <= tmr_tick ? 20'h0_0000 : gap_t + 20'h0_0001;
      seen_p <= seen_p | pld_tick;
      seen_t <= seen_t | tmr_tick;
      cfg_p  <= pld_tick ? s_q.clk_cfg : cfg_p;
      cfg_t  <= tmr_tick ? s_q.clk_cfg : cfg_t;
    end
  end

  pld_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pld_tick && seen_p && !ext_sel && cfg_p == s_q.clk_cfg) |->
      gap_p == 20'((OSC_DIV << pdiv) - 1))
    else $error("array tick period wrong");

  tmr_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tmr_tick && seen_t && !ext_sel && cfg_t == s_q.clk_cfg) |->
      gap_t == 20'((OSC_DIV << ({1'b0, tdiv} + 4'h2)) - 1))
    else $error("timer tick period wrong");

  pin_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pld_tick && !ext_sel) |=> !clk_pin_oe)
    else $error("clock pin not released at array tick");

  pin_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_sel |=> !clk_pin_oe)
    else $error("clock pin driven in external mode");

  toggle_ff_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pld_tick && s_q.mc_cfg[0][MC_T_BIT] && !arst[0] && !apre[0]) |=>
      s_q.mc_q[0] == ($past(s_q.mc_q[0]) ^ $past(sum[0])))
    else $error("toggle flip-flop wrong");

  bypass_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.mc_cfg[0][MC_BYP_BIT] |=> s_q.mc_out[0] == $past(sum[0]))
    else $error("bypass output wrong");

  pin_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.mc_cfg[0][MC_RST_LSB +: 2] == SRC_GRST && grst) |=> !s_q.mc_q[0])
    else $error("cell not cleared by reset pin");

  samp_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !pld_tick |=> $stable(s_q.samp))
    else $error("inputs sampled off the array tick");

endmodule

// File: spct_partner.sv
// Far-side model: comparators, digital pins, reset pin and clock pin source.
// Assumes a pull-up on the clock pin; the bench sets levels by name.
`timescale 1ns/1ps
module spct_partner (
  input  wire logic        clk_pin_oe, // Core pulls the clock pin low
  output logic [11:0]      cmp_in,     // Comparator levels
  output logic [3:0]       dig_in,     // Digital pin levels
  output logic             rst_pin_n,  // Global reset pin
  output logic             clk_pin_i   // Resolved clock pin level
);
  logic ext_on;
  logic ext_clk;
  initial begin
    cmp_in = '0;
    dig_in = '0;
    rst_pin_n = 1'b1;
    ext_on = 1'b0;
    ext_clk = 1'b0;
    #3;
    // Free-running source, edges kept clear of hclk edges
    forever #40 ext_clk = ~ext_clk;
  end
  assign clk_pin_i = clk_pin_oe ? 1'b0 : (ext_on ? ext_clk : 1'b1);
endmodule

// File: tb_sequencer_pld_clock_timers.sv
// Self-checking bench for spct_core over AHB-Lite with the far-side model.
// Assumes 125 MHz hclk and word-only single transfers.
`timescale 1ns/1ps
module tb_sequencer_pld_clock_timers;
  import spct_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [11:0] cmp_in;
  logic [3:0]  dig_in;
  logic        rst_pin_n;
  logic        clk_pin_i;
  logic        clk_pin_oe;
  logic [3:0]  hv_drive;
  logic [3:0]  hv_oe;
  logic [15:0] pld_out;
  logic [31:0] rd;
  int          n_fail;
  int          num_checks;
  int          cyc;
  int          g;

  spct_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .cmp_in(cmp_in), .dig_in(dig_in),
    .rst_pin_n(rst_pin_n), .clk_pin_i(clk_pin_i), .clk_pin_o(), .clk_pin_oe(clk_pin_oe),
    .high_voltage_gate_output_drive(hv_drive), .high_voltage_gate_output_oe(hv_oe),
    .high_voltage_gate_output_o(), .pld_out(pld_out));
  spct_partner u_part (.clk_pin_oe(clk_pin_oe), .cmp_in(cmp_in), .dig_in(dig_in),
    .rst_pin_n(rst_pin_n), .clk_pin_i(clk_pin_i));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0000_0000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Cycles between two successive changes of the picked output
  task automatic gap(input bit pick, output int n);
    logic v;
    n = 0;
    @(posedge hclk);
    v = pick ? pld_out[0] : clk_pin_oe;
    while ((pick ? pld_out[0] : clk_pin_oe) === v) @(posedge hclk);
    v = pick ? pld_out[0] : clk_pin_oe;
    while ((pick ? pld_out[0] : clk_pin_oe) === v) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic t_reset;
    chk(hreadyout, 1'b1);
    ahb(1'b0, ADDR_STATUS, '0);
    chk(rd[20], 1'b1);
    chk(rd[19:0], '0);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h40, '0);
    chk(rd, '0);
  endtask

  task automatic t_clkpin;
    ahb(1'b1, ADDR_CLK_CFG, 32'h0000_0000);
    gap(1'b0, g);
    chk(g, OSC_DIV / 2);
    ahb(1'b1, ADDR_CLK_CFG, 32'h0000_0002);
    ahb(1'b0, ADDR_CLK_CFG, '0);
    chk(rd, 32'h0000_0002);
    gap(1'b0, g);
    chk(g, OSC_DIV * 2);
    ahb(1'b1, ADDR_CLK_CFG, 32'h0000_0000);
  endtask

  task automatic t_logic;
    ahb(1'b1, ADDR_PT_SEL, 32'h0000_0000);
    ahb(1'b1, ADDR_PT_TRUE, 32'h0000_0001);
    ahb(1'b1, ADDR_PT_HI, 32'h0000_0100);
    ahb(1'b1, ADDR_OUT_CFG, 32'h0000_0001);
    u_part.cmp_in[0] <= 1'b1;
    repeat (1100) @(posedge hclk);
    chk(pld_out[0], 1'b1);
    chk({hv_drive[0], hv_oe[0]}, 2'b10);
    ahb(1'b1, ADDR_OUT_CFG, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    chk({hv_drive[0], hv_oe[0]}, 2'b00);
    // Cell 0 lends its cluster to cell 1
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0008);
    repeat (1100) @(posedge hclk);
    chk(pld_out[1:0], 2'b10);
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0000);
    u_part.cmp_in[0] <= 1'b0;
    repeat (1100) @(posedge hclk);
    chk({pld_out[0], hv_oe[0]}, 2'b01);
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0004);
    repeat (1100) @(posedge hclk);
    chk(pld_out[0], 1'b1);
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0005);
    gap(1'b1, g);
    chk(g, OSC_DIV);
    // Bypass follows the sum within a cycle, long before the next tick
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0006);
    repeat (2) @(posedge hclk);
    chk(pld_out[0], 1'b1);
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0002);
    repeat (2) @(posedge hclk);
    chk(pld_out[0], 1'b0);
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0000);
  endtask

  task automatic t_timer;
    int t0;
    // Timer 2 is gated by cell 1, which stays low
    ahb(1'b1, ADDR_TMR_GATE, 32'h0000_0100);
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, ADDR_TMR_CFG, 32'(k | ((k + 1) << 3)));
      u_part.cmp_in[0] <= 1'b1;
      // Time from the gate rise, so leftover cell state cannot skew it
      while (pld_out[0] !== 1'b0) @(posedge hclk);
      while (pld_out[0] !== 1'b1) @(posedge hclk);
      t0 = cyc;
      do ahb(1'b0, ADDR_STATUS, '0); while (rd[16] !== 1'b1);
      chk(rd[17], 1'b0);
      chk(rd[18], 1'b0);
      chk((cyc - t0) >= ((8 << k) - 3) * OSC_DIV, 1'b1);
      chk((cyc - t0) <= (8 << k) * OSC_DIV + 16, 1'b1);
      u_part.cmp_in[0] <= 1'b0;
      repeat (1100) @(posedge hclk);
      ahb(1'b0, ADDR_STATUS, '0);
      chk(rd[19:16], '0);
    end
  endtask

  task automatic t_rstpin;
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0020);
    u_part.cmp_in[0] <= 1'b1;
    repeat (1100) @(posedge hclk);
    chk(pld_out[0], 1'b1);
    u_part.rst_pin_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk(pld_out[0], 1'b0);
    ahb(1'b0, ADDR_STATUS, '0);
    chk(rd[19:16], '0);
    u_part.rst_pin_n <= 1'b1;
    u_part.cmp_in[0] <= 1'b0;
  endtask

  task automatic t_ext;
    ahb(1'b1, ADDR_CLK_CFG, 32'h0000_0100);
    u_part.ext_on <= 1'b1;
    ahb(1'b1, ADDR_MC_CFG0, 32'h0000_0005);
    gap(1'b1, g);
    chk(g, 10);
    chk(clk_pin_oe, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge hclk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    cyc = 0;
    n_fail = 0;
    num_checks = 0;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_clkpin();
    t_logic();
    t_timer();
    t_rstpin();
    t_ext();
    tally_and_finish();
  end
endmodule
